// ---- include/drive_param_pkg.sv ----
// How it works
// - Eight preset speeds in 0.01 Hz steps each take zero or a value from the start to the top frequency, for presets 1 to 7 that of the active motor set.
// - The jog frequency in 0.01 Hz steps takes values from the start frequency up to 999.
// - Jog stop codes 0 to 2 pick free-run, deceleration or DC braking with no jog while running; 3 to 5 allow it.
// - Boost selection code 0 is manual boost and code 1 is automatic boost.
// - The manual boost amount takes 0 to 200 in 0.1 percent steps.
// - The manual boost break-point takes 0 to 500 in 0.1 percent steps.
// - The curve field decodes 0 as constant torque, 1 as reduced torque and 2 as a free curve.
// - The automatic boost voltage gain takes 0 to 255 percent.
// - The automatic boost slip gain takes 0 to 255 percent.
package drive_param_pkg;

	// Register file shape
	localparam int NUM_REGS     = 17;
	localparam int PRESET_COUNT = 8;
	localparam int DATA_W       = 16;
	localparam int SLOT_W       = 5;

	// Register indices; the byte address is four times the index
	localparam logic [15:0] REG_INDEX [NUM_REGS] = '{
		16'h1217, 16'h1219, 16'h121B, 16'h121D, 16'h121F, 16'h1221, 16'h1223, 16'h1225,
		16'h1238, 16'h1239, 16'h123B, 16'h123C, 16'h123D, 16'h123E, 16'h123F, 16'h1240, 16'h1241};
	localparam logic [15:0] STATUS_INDEX = 16'h12F0;

	// Slot numbers inside the register file
	localparam int SLOT_JOG_FREQ   = 8;
	localparam int SLOT_JOG_STOP   = 9;
	localparam int SLOT_BOOST_SEL  = 10;
	localparam int SLOT_BOOST_AMT  = 11;
	localparam int SLOT_BOOST_BRK  = 12;
	localparam int SLOT_VF_CURVE   = 13;
	localparam int SLOT_VF_GAIN    = 14;
	localparam int SLOT_VOLT_GAIN  = 15;
	localparam int SLOT_SLIP_GAIN  = 16;

	// Values after reset, one per slot
	localparam logic [15:0] RESET_VAL [NUM_REGS] = '{
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0064, 16'h0004, 16'h0000, 16'h0032, 16'h0064, 16'h0000, 16'h0064, 16'h0064, 16'h0064};

	// Legal limits
	localparam logic [15:0] ZERO_VAL         = 16'h0000;
	localparam logic [15:0] JOG_FREQ_MAX     = 16'h03E7;
	localparam logic [15:0] JOG_STOP_MAX     = 16'h0005;
	localparam logic [15:0] JOG_RUN_OK_MIN   = 16'h0003;
	localparam logic [15:0] BOOST_SEL_MAX    = 16'h0001;
	localparam logic [15:0] BOOST_AUTO_CODE  = 16'h0001;
	localparam logic [15:0] BOOST_AMOUNT_MAX = 16'h00C8;
	localparam logic [15:0] BOOST_BRK_MAX    = 16'h01F4;
	localparam logic [15:0] VF_CURVE_MAX     = 16'h0002;
	localparam logic [15:0] VF_GAIN_MIN      = 16'h0014;
	localparam logic [15:0] VF_GAIN_MAX      = 16'h0064;
	localparam logic [15:0] COMP_GAIN_MAX    = 16'h00FF;

	// Decoded encodings
	typedef enum logic [1:0] {
		VF_CONSTANT = 2'b00,
		VF_REDUCED  = 2'b01,
		VF_FREE     = 2'b10
	} vf_curve_t;
	typedef enum logic [1:0] {
		JOG_FREE_RUN = 2'b00,
		JOG_DECEL    = 2'b01,
		JOG_DC_BRAKE = 2'b10
	} jog_stop_t;

	// Status word bit positions
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_PERMIT_BIT = 1;
	localparam int STAT_REJECT_BIT = 2;

	// Timing
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned SETTLE_TIME_MS = 40;
	localparam int unsigned SETTLE_CYCLES  = SETTLE_TIME_MS * (CLK_HZ / 1000);

	// Bus answers
	localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

endpackage

// ---- src/param_slot.sv ----
`timescale 1ns/100ps
`default_nettype none
// One parameter register with its own range check
module param_slot #(
	parameter int                       W           = 16,
	parameter logic [W-1:0]             RESET_VALUE = '0
) (
	// Clock and reset
	input  wire logic          i_core_clk,
	input  wire logic          i_arst_n,
	// Candidate value and its bounds
	input  wire logic          i_load,
	input  wire logic [W-1:0]  i_value,
	input  wire logic [W-1:0]  i_low,
	input  wire logic [W-1:0]  i_high,
	input  wire logic          i_zero_ok,
	// Result
	output logic               o_legal,
	output logic [W-1:0]       o_value
);

	// Zero may be a legal escape below the lower bound
	assign o_legal = (i_zero_ok && (i_value == '0)) || ((i_value >= i_low) && (i_value <= i_high));

	// Illegal candidates leave the old value in place
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_value <= RESET_VALUE;
		end else if (i_load && o_legal) begin
			o_value <= i_value;
		end
	end

endmodule // param_slot
`default_nettype wire

// ---- src/drive_param_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
module drive_param_bank #(
	parameter int unsigned SETTLE_CYCLES = drive_param_pkg::SETTLE_CYCLES
) (
	// Clock and reset
	input  wire logic                  i_core_clk,
	input  wire logic                  i_arst_n,
	// Avalon-MM slave
	input  wire logic [15:0]           i_avs_address,
	input  wire logic                  i_avs_read,
	input  wire logic                  i_avs_write,
	input  wire logic [31:0]           i_avs_writedata,
	input  wire logic [3:0]            i_avs_byteenable,
	output logic [31:0]                o_avs_readdata,
	output logic                       o_avs_waitrequest,
	// Drive context, frequencies in 0.01 Hz
	input  wire logic [15:0]           i_start_freq,
	input  wire logic [15:0]           i_top_freq,
	input  wire logic [15:0]           i_second_top_freq,
	input  wire logic                  i_second_set_active,
	input  wire logic                  i_running,
	// Parameter values to the control logic
	output logic [7:0][15:0]           o_preset_speed,
	output logic [15:0]                o_inching_frequency,
	output logic [1:0]                 o_inching_stop_kind,
	output logic                       o_jog_permit,
	output logic                       o_boost_auto,
	output logic [15:0]                o_manual_boost_amount,
	output logic [15:0]                o_manual_boost_breakpoint,
	output logic [1:0]                 o_vf_curve,
	output logic [15:0]                o_vf_gain,
	output logic [15:0]                o_auto_boost_voltage_gain,
	output logic [15:0]                o_auto_boost_slip_gain,
	output logic                       o_settle_busy
);

	localparam int N = drive_param_pkg::NUM_REGS;

	logic [15:0]   store [N];
	logic [15:0]   low_b [N];
	logic [15:0]   high_b [N];
	logic [N-1:0]  zero_ok;
	logic [N-1:0]  legal_vec;
	logic [13:0]   word_index;
	logic          hit;
	logic          status_hit;
	logic [4:0]    slot;
	logic [15:0]   old_val;
	logic [15:0]   wdata_m;
	logic          wr_take;
	logic          wr_legal;
	logic          ack_reg;
	logic [31:0]   rdata_reg;
	logic [31:0]   rdata_next;
	logic [31:0]   settle_reg;
	logic          reject_reg;
	logic          permit_reg;
	logic [1:0]    stop_kind_reg;
	logic [15:0]   top_eff;

	// Address decode; unaligned or unlisted words miss
	assign word_index = i_avs_address[15:2];
	always_comb begin
		hit = 1'b0;
		status_hit = 1'b0;
		slot = '0;
		if (i_avs_address[1:0] != 2'b00) begin
			hit = 1'b0;
		end else if ({2'b00, word_index} == drive_param_pkg::STATUS_INDEX) begin
			status_hit = 1'b1;
		end else begin
			for (int i = 0; i < N; i++) begin
				if ({2'b00, word_index} == drive_param_pkg::REG_INDEX[i]) begin
					hit = 1'b1;
					slot = 5'(i);
				end
			end
		end
	end

	// One wait cycle per access keeps decode and range check off the bus path
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
		end
	end

	// Byte lanes 0 and 1 merge over the stored value before the check
	assign old_val = hit ? store[slot] : 16'h0000;
	assign wdata_m = {i_avs_byteenable[1] ? i_avs_writedata[15:8] : old_val[15:8],
	                  i_avs_byteenable[0] ? i_avs_writedata[7:0] : old_val[7:0]};
	assign wr_take = i_avs_write && ack_reg && hit;
	assign wr_legal = legal_vec[slot];

	// Top frequency for presets 1 to 7 follows the active motor set
	assign top_eff = i_second_set_active ? i_second_top_freq : i_top_freq;

	// Bounds per slot
	always_comb begin
		for (int i = 0; i < N; i++) begin
			low_b[i] = drive_param_pkg::ZERO_VAL;
			high_b[i] = drive_param_pkg::ZERO_VAL;
			zero_ok[i] = 1'b0;
		end
		for (int i = 0; i < drive_param_pkg::PRESET_COUNT; i++) begin
			low_b[i] = i_start_freq;
			high_b[i] = (i == 0) ? i_top_freq : top_eff;
			zero_ok[i] = 1'b1;
		end
		low_b[drive_param_pkg::SLOT_JOG_FREQ] = i_start_freq;
		high_b[drive_param_pkg::SLOT_JOG_FREQ] = drive_param_pkg::JOG_FREQ_MAX;
		high_b[drive_param_pkg::SLOT_JOG_STOP] = drive_param_pkg::JOG_STOP_MAX;
		high_b[drive_param_pkg::SLOT_BOOST_SEL] = drive_param_pkg::BOOST_SEL_MAX;
		high_b[drive_param_pkg::SLOT_BOOST_AMT] = drive_param_pkg::BOOST_AMOUNT_MAX;
		high_b[drive_param_pkg::SLOT_BOOST_BRK] = drive_param_pkg::BOOST_BRK_MAX;
		high_b[drive_param_pkg::SLOT_VF_CURVE] = drive_param_pkg::VF_CURVE_MAX;
		low_b[drive_param_pkg::SLOT_VF_GAIN] = drive_param_pkg::VF_GAIN_MIN;
		high_b[drive_param_pkg::SLOT_VF_GAIN] = drive_param_pkg::VF_GAIN_MAX;
		high_b[drive_param_pkg::SLOT_VOLT_GAIN] = drive_param_pkg::COMP_GAIN_MAX;
		high_b[drive_param_pkg::SLOT_SLIP_GAIN] = drive_param_pkg::COMP_GAIN_MAX;
	end

	// One register per slot
	generate
		for (genvar g = 0; g < N; g++) begin : g_slot
			param_slot #(
				.W           (drive_param_pkg::DATA_W),
				.RESET_VALUE (drive_param_pkg::RESET_VAL[g])
			) u_slot (
				.i_core_clk (i_core_clk),
				.i_arst_n   (i_arst_n),
				.i_load     (wr_take && (slot == 5'(g))),
				.i_value    (wdata_m),
				.i_low      (low_b[g]),
				.i_high     (high_b[g]),
				.i_zero_ok  (zero_ok[g]),
				.o_legal    (legal_vec[g]),
				.o_value    (store[g])
			);
		end
	endgenerate

	// Read data is loaded in the wait cycle and stands through the answer
	always_comb begin
		rdata_next = drive_param_pkg::RDATA_UNMAPPED;
		if (hit) begin
			rdata_next = {16'h0000, store[slot]};
		end else if (status_hit) begin
			rdata_next[drive_param_pkg::STAT_BUSY_BIT] = o_settle_busy;
			rdata_next[drive_param_pkg::STAT_PERMIT_BIT] = permit_reg;
			rdata_next[drive_param_pkg::STAT_REJECT_BIT] = reject_reg;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (i_avs_read && !ack_reg) begin
			rdata_reg <= rdata_next;
		end
	end
	assign o_avs_readdata = rdata_reg;

	// Outcome of the latest write to a real register
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			reject_reg <= 1'b0;
		end else if (wr_take) begin
			reject_reg <= !wr_legal;
		end
	end

	// Settle timer restarts on every accepted change; it only informs, it blocks nothing
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			settle_reg <= 32'h0000_0000;
		end else if (wr_take && wr_legal) begin
			settle_reg <= SETTLE_CYCLES;
		end else if (settle_reg != 32'h0000_0000) begin
			settle_reg <= settle_reg - 32'h0000_0001;
		end
	end
	assign o_settle_busy = (settle_reg != 32'h0000_0000);

	// Jog stop decode and run-time jog permission
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			permit_reg <= 1'b0;
			stop_kind_reg <= drive_param_pkg::JOG_FREE_RUN;
		end else begin
			permit_reg <= !i_running || (store[drive_param_pkg::SLOT_JOG_STOP] >= drive_param_pkg::JOG_RUN_OK_MIN);
			if (store[drive_param_pkg::SLOT_JOG_STOP] >= drive_param_pkg::JOG_RUN_OK_MIN) begin
				stop_kind_reg <= 2'(store[drive_param_pkg::SLOT_JOG_STOP] - drive_param_pkg::JOG_RUN_OK_MIN);
			end else begin
				stop_kind_reg <= store[drive_param_pkg::SLOT_JOG_STOP][1:0];
			end
		end
	end
	assign o_jog_permit = permit_reg;
	assign o_inching_stop_kind = stop_kind_reg;

	// Values to the control logic
	generate
		for (genvar p = 0; p < drive_param_pkg::PRESET_COUNT; p++) begin : g_preset
			assign o_preset_speed[p] = store[p];
		end
	endgenerate
	assign o_inching_frequency = store[drive_param_pkg::SLOT_JOG_FREQ];
	assign o_boost_auto = (store[drive_param_pkg::SLOT_BOOST_SEL] == drive_param_pkg::BOOST_AUTO_CODE);
	assign o_manual_boost_amount = store[drive_param_pkg::SLOT_BOOST_AMT];
	assign o_manual_boost_breakpoint = store[drive_param_pkg::SLOT_BOOST_BRK];
	assign o_vf_curve = store[drive_param_pkg::SLOT_VF_CURVE][1:0];
	assign o_vf_gain = store[drive_param_pkg::SLOT_VF_GAIN];
	assign o_auto_boost_voltage_gain = store[drive_param_pkg::SLOT_VOLT_GAIN];
	assign o_auto_boost_slip_gain = store[drive_param_pkg::SLOT_SLIP_GAIN];

	// Helper state for the checks: one write, seen one cycle later
	logic          take_d;
	logic          legal_d;
	logic [4:0]    slot_d;
	logic [15:0]   data_d;
	logic [15:0]   old_d;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			take_d <= 1'b0;
			legal_d <= 1'b0;
			slot_d <= '0;
			data_d <= 16'h0000;
			old_d <= 16'h0000;
		end else begin
			take_d <= wr_take;
			legal_d <= wr_legal;
			slot_d <= slot;
			data_d <= wdata_m;
			old_d <= old_val;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	chk_preset_range: assert property (
		wr_take && slot < 5'(drive_param_pkg::PRESET_COUNT) && wdata_m != 16'h0000 && wdata_m < i_start_freq
		|-> !wr_legal) else $error("preset below start frequency accepted");
	chk_settle_busy: assert property (
		wr_take && wr_legal |=> o_settle_busy [*8]) else $error("settle flag not held after change");
	chk_jog_freq_max: assert property (
		wr_take && slot == 5'(drive_param_pkg::SLOT_JOG_FREQ) && wdata_m > drive_param_pkg::JOG_FREQ_MAX
		|-> !wr_legal) else $error("jog frequency above limit accepted");
	chk_jog_run_block: assert property (
		i_running && !wr_take && store[drive_param_pkg::SLOT_JOG_STOP] < drive_param_pkg::JOG_RUN_OK_MIN
		|=> !o_jog_permit) else $error("jog permitted while running");
	chk_boost_decode: assert property (
		take_d && legal_d && slot_d == 5'(drive_param_pkg::SLOT_BOOST_SEL)
		|-> o_boost_auto == (data_d == drive_param_pkg::BOOST_AUTO_CODE)) else $error("boost select decode wrong");
	chk_boost_amount: assert property (
		wr_take && slot == 5'(drive_param_pkg::SLOT_BOOST_AMT) && wdata_m > drive_param_pkg::BOOST_AMOUNT_MAX
		|-> !wr_legal) else $error("boost amount above limit accepted");
	chk_boost_breakpoint: assert property (
		wr_take && slot == 5'(drive_param_pkg::SLOT_BOOST_BRK) && wdata_m > drive_param_pkg::BOOST_BRK_MAX
		|-> !wr_legal) else $error("break-point above limit accepted");
	chk_curve_code: assert property (
		o_vf_curve != 2'b11 && store[drive_param_pkg::SLOT_VF_CURVE] <= drive_param_pkg::VF_CURVE_MAX)
		else $error("curve code out of range");
	chk_volt_gain: assert property (
		store[drive_param_pkg::SLOT_VOLT_GAIN] <= drive_param_pkg::COMP_GAIN_MAX) else $error("voltage gain too big");
	chk_slip_gain: assert property (
		store[drive_param_pkg::SLOT_SLIP_GAIN] <= drive_param_pkg::COMP_GAIN_MAX) else $error("slip gain too big");
	chk_reject_keep: assert property (
		take_d && !legal_d |-> store[slot_d] == old_d && reject_reg) else $error("rejected write changed value");
	chk_accept_store: assert property (
		take_d && legal_d |-> store[slot_d] == data_d && !reject_reg) else $error("legal write not stored");
	chk_reserved_read: assert property (
		i_avs_read && !ack_reg && !hit && !status_hit |=> o_avs_readdata == drive_param_pkg::RDATA_UNMAPPED)
		else $error("reserved address returned data");

	// Bus timing, lower and upper edges of the ranges, and the stop decode
	chk_one_wait: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	chk_preset0_top: assert property (
		wr_take && slot == 5'(0) && wdata_m > i_top_freq
		|-> !wr_legal) else $error("preset 0 above top frequency accepted");
	chk_jog_freq_low: assert property (
		wr_take && slot == 5'(drive_param_pkg::SLOT_JOG_FREQ) && wdata_m < i_start_freq
		|-> !wr_legal) else $error("jog frequency below start accepted");
	chk_vf_gain_range: assert property (
		wr_take && slot == 5'(drive_param_pkg::SLOT_VF_GAIN)
		&& (wdata_m < drive_param_pkg::VF_GAIN_MIN || wdata_m > drive_param_pkg::VF_GAIN_MAX)
		|-> !wr_legal) else $error("volts per hertz gain out of range accepted");
	chk_stop_decode: assert property (
		1'b1 |=> o_inching_stop_kind == 2'($past(store[drive_param_pkg::SLOT_JOG_STOP]) % 16'h0003))
		else $error("jog stop kind decode wrong");

	cov_accept: cover property (wr_take && wr_legal);
	cov_reject: cover property (wr_take && !wr_legal);
	cov_reserved: cover property (i_avs_read && ack_reg && !hit && !status_hit);
	cov_jog_running: cover property (i_running && o_jog_permit);
	cov_status_read: cover property (i_avs_read && ack_reg && status_hit);

endmodule // drive_param_bank
`default_nettype wire

// ---- tb/avm_master_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Avalon-MM master standing in for the remote network master
module avm_master_model (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	// Command from the bench
	input  wire logic        i_go,
	input  wire logic        i_wr,
	input  wire logic [15:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_be,
	output logic             o_done,
	output logic [31:0]      o_rdata,
	// Avalon-MM master side
	output logic [15:0]      o_avm_address,
	output logic             o_avm_read,
	output logic             o_avm_write,
	output logic [31:0]      o_avm_writedata,
	output logic [3:0]       o_avm_byteenable,
	input  wire logic [31:0] i_avm_readdata,
	input  wire logic        i_avm_waitrequest
);
	// One transfer at a time, held until waitrequest is seen low
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_avm_read <= 1'b0;
			o_avm_write <= 1'b0;
			o_avm_address <= 16'h0000;
			o_avm_writedata <= 32'h0000_0000;
			o_avm_byteenable <= 4'h0;
			o_done <= 1'b0;
			o_rdata <= 32'h0000_0000;
		end else begin
			o_done <= 1'b0;
			if ((o_avm_read || o_avm_write) && !i_avm_waitrequest) begin
				o_avm_read <= 1'b0;
				o_avm_write <= 1'b0;
				// Released lines flip so stale data never looks valid
				o_avm_writedata <= ~o_avm_writedata;
				o_avm_address <= ~o_avm_address;
				o_rdata <= i_avm_readdata;
				o_done <= 1'b1;
			end else if (i_go && !o_avm_read && !o_avm_write) begin
				o_avm_read <= !i_wr;
				o_avm_write <= i_wr;
				o_avm_address <= i_addr;
				o_avm_writedata <= i_wdata;
				o_avm_byteenable <= i_be;
			end
		end
	end
endmodule // avm_master_model
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int SETTLE = 20;
	logic              clk, rst_n, go, wr, done, running, sec, rd_q, wr_q, wait_q, busy, permit, auto;
	logic [15:0]       addr, start_f, top_f, top2_f, a_q, lo, hi, jog_f, amt, brk, vfg, vg, sg;
	logic [31:0]       wdata, rd, wd_q, rdat_q;
	logic [3:0]        be, be_q;
	logic [1:0]        stop_k, curve;
	logic [7:0][15:0]  preset;
	logic [15:0]       exp_reg [17];
	logic [15:0]       cand [7];
	int                n_mismatch, check_count;

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	avm_master_model master (.i_core_clk(clk), .i_arst_n(rst_n), .i_go(go), .i_wr(wr), .i_addr(addr),
		.i_wdata(wdata), .i_be(be), .o_done(done), .o_rdata(rd), .o_avm_address(a_q), .o_avm_read(rd_q),
		.o_avm_write(wr_q), .o_avm_writedata(wd_q), .o_avm_byteenable(be_q), .i_avm_readdata(rdat_q),
		.i_avm_waitrequest(wait_q));
	drive_param_bank #(.SETTLE_CYCLES(SETTLE)) uut (.i_core_clk(clk), .i_arst_n(rst_n), .i_avs_address(a_q),
		.i_avs_read(rd_q), .i_avs_write(wr_q), .i_avs_writedata(wd_q), .i_avs_byteenable(be_q),
		.o_avs_readdata(rdat_q), .o_avs_waitrequest(wait_q), .i_start_freq(start_f), .i_top_freq(top_f),
		.i_second_top_freq(top2_f), .i_second_set_active(sec), .i_running(running), .o_preset_speed(preset),
		.o_inching_frequency(jog_f), .o_inching_stop_kind(stop_k), .o_jog_permit(permit), .o_boost_auto(auto),
		.o_manual_boost_amount(amt), .o_manual_boost_breakpoint(brk), .o_vf_curve(curve), .o_vf_gain(vfg),
		.o_auto_boost_voltage_gain(vg), .o_auto_boost_slip_gain(sg), .o_settle_busy(busy));

	task automatic print_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check_val(input logic [15:0] got, input logic [15:0] want);
		check_count++;
		if (got !== want) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, got, want);
		end
	endtask

	task automatic check_bit(input logic got, input logic want);
		check_val({15'h0000, got}, {15'h0000, want});
	endtask

	// One bus transfer through the master model, bounded wait
	task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [3:0] b);
		int i;
		@(posedge clk);
		go <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= {16'h0000, d};
		be <= b;
		@(posedge clk);
		go <= 1'b0;
		for (i = 0; i < 20 && done !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (done !== 1'b1) begin
			n_mismatch++;
			$display("wrong value at %0t: bus hang", $time);
		end
	endtask

	function automatic logic [15:0] addr_of(int s);
		return {drive_param_pkg::REG_INDEX[s][13:0], 2'b00};
	endfunction

	// Legal window of each slot from the drive context
	function automatic void bounds(int s, output logic [15:0] l, output logic [15:0] h);
		l = 16'h0000;
		case (s) inside
			[0:7]: begin
				l = start_f;
				h = (s != 0 && sec) ? top2_f : top_f;
			end
			8: begin
				l = start_f;
				h = 16'h03E7;
			end
			9: h = 16'h0005;
			10: h = 16'h0001;
			11: h = 16'h00C8;
			12: h = 16'h01F4;
			13: h = 16'h0002;
			14: begin
				l = 16'h0014;
				h = 16'h0064;
			end
			default: h = 16'h00FF;
		endcase
	endfunction

	function automatic logic [15:0] out_of(int s);
		case (s) inside
			[0:7]: return preset[s];
			8: return jog_f;
			9: return {14'h0000, stop_k};
			10: return {15'h0000, auto};
			11: return amt;
			12: return brk;
			13: return {14'h0000, curve};
			14: return vfg;
			15: return vg;
			default: return sg;
		endcase
	endfunction

	// Write with byte lanes merged over the stored value; illegal results are kept out of the model
	task automatic put(input int s, input logic [15:0] v, input logic [3:0] b);
		logic [15:0] m;
		logic [15:0] l;
		logic [15:0] h;
		m = {b[1] ? v[15:8] : exp_reg[s][15:8], b[0] ? v[7:0] : exp_reg[s][7:0]};
		access(1'b1, addr_of(s), v, b);
		bounds(s, l, h);
		if ((m >= l && m <= h) || (s < 8 && m == 16'h0000))
			exp_reg[s] = m;
	endtask

	task automatic readback(input int s);
		access(1'b0, addr_of(s), 16'h0000, 4'hF);
		check_val(rd[15:0], exp_reg[s]);
	endtask

	// Watchdog
	initial begin
		#300_000;
		n_mismatch++;
		$display("wrong value at %0t: run hung", $time);
		print_verdict();
	end

	initial begin
		int s;
		int k;
		logic [15:0] rsv [3];
		clk = 1'b0;
		rst_n = 1'b0;
		go = 1'b0;
		wr = 1'b0;
		addr = 16'h0000;
		wdata = 32'h0000_0000;
		be = 4'h0;
		start_f = 16'h0064;
		top_f = 16'h1770;
		top2_f = 16'h0BB8;
		sec = 1'b0;
		running = 1'b0;
		n_mismatch = 0;
		check_count = 0;
		rsv = '{16'h1218, 16'h123A, 16'h1226};
		k = $urandom(32'hdb3d);
		for (s = 0; s < 17; s++)
			exp_reg[s] = drive_param_pkg::RESET_VAL[s];
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, then each slot's edges of range plus random values
		for (s = 0; s < 17; s++)
			readback(s);
		for (s = 0; s < 17; s++) begin
			@(posedge clk);
			sec <= 1'($urandom % 2);
			@(posedge clk);
			bounds(s, lo, hi);
			cand = '{lo - 16'h0001, lo, hi, hi + 16'h0001, 16'h0000, 16'($urandom),
				lo + 16'($urandom % (32'(hi - lo) + 1))};
			for (k = 0; k < 7; k++) begin
				put(s, cand[k], 4'hF);
				readback(s);
			end
			repeat (2) @(posedge clk);
			#1;
			check_val(out_of(s), (s == 9) ? exp_reg[s] % 3 : exp_reg[s]);
		end
		// Single byte lane merges before the range check
		put(11, 16'hFF10, 4'b0001);
		readback(11);
		// Reserved places keep nothing and read zero
		for (k = 0; k < 3; k++) begin
			access(1'b1, {rsv[k][13:0], 2'b00}, 16'h1234, 4'hF);
			access(1'b0, {rsv[k][13:0], 2'b00}, 16'h0000, 4'hF);
			check_val(rd[15:0], 16'h0000);
		end
		readback(0);
		// Settle time before running, then jog permission by stop code
		put(9, 16'h0001, 4'hF);
		check_bit(busy, 1'b1);
		access(1'b0, {drive_param_pkg::STATUS_INDEX[13:0], 2'b00}, 16'h0000, 4'hF);
		check_val(rd[15:0], 16'h0003);
		for (k = 0; k < SETTLE + 10 && busy !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		check_bit(busy, 1'b0);
		@(posedge clk);
		running <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check_bit(permit, 1'b0);
		put(9, 16'h0004, 4'hF);
		repeat (2) @(posedge clk);
		#1;
		check_bit(permit, 1'b1);
		put(9, 16'h0007, 4'hF);
		repeat (2) @(posedge clk);
		#1;
		check_bit(permit, 1'b1);
		check_val({14'h0000, stop_k}, 16'h0001);
		// Once settled, the status word shows permission and the rejected write
		for (k = 0; k < SETTLE + 10 && busy !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		access(1'b0, {drive_param_pkg::STATUS_INDEX[13:0], 2'b00}, 16'h0000, 4'hF);
		check_val(rd[15:0], 16'h0006);
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
